//--- design/pbmc_top.sv
// basic mode control register upper bits behind an ahb-lite slave
//
// Overview of operation
// - writing reset bit starts soft reset; bit reads one until done, then clears
// - soft reset reloads configuration from strap inputs like power-on
// - loopback bit one routes mii transmit data back to receive path
// - speed bit picks 100 or 10 Mb/s when autoneg off; resets from strap
// - autoneg enable resets from strap and software may rewrite it later
// - autoneg on ignores speed and duplex bits; off they drive speed and duplex
// - power-down bit powers down transceiver; only register block stays alive
// - effective power-down is bit OR low pin; pin assertion sets the bit
// - isolate bit disconnects port from mii, management stays active
// - duplex bit selects full when one, half when zero, with autoneg off
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "pbmc_cfg.svh"

module pbmc_top #(
   parameter logic [15:0] RST_CYCLES = `PBMC_RST_CYCLES
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic strap_speed_100,
   input wire logic strap_aneg_en,
   input wire logic strap_full_duplex,
   input wire logic power_down_irq_pin_n,
   input wire logic [3:0] mii_txd,
   input wire logic mii_tx_en,
   input wire logic [3:0] line_rxd,
   input wire logic line_rx_dv,
   output logic [3:0] mii_rxd,
   output logic mii_rx_dv,
   output logic [3:0] line_txd,
   output logic line_tx_en,
   output logic mii_out_en,
   output logic core_reset,
   output logic power_down,
   output logic speed_100,
   output logic full_duplex,
   output logic aneg_enable
);

   // power-down pin synchroniser; reset value is the pin's idle level
   logic [1:0] pd_sync_r;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pd_sync_r <= 2'b11;
      end else begin
         pd_sync_r <= {pd_sync_r[0], power_down_irq_pin_n};
      end
   end
   wire pin_pd = ~pd_sync_r[1];

   // strap synchronisers keep running through reset, so the load state
   // after release sees the real straps, not a reset value of zero
   // limitation: a power-on reset must span at least two clock edges
   logic [1:0] ss_sync_r;
   logic [1:0] sa_sync_r;
   logic [1:0] sd_sync_r;
   always_ff @(posedge mclk) begin
      ss_sync_r <= {ss_sync_r[0], strap_speed_100};
      sa_sync_r <= {sa_sync_r[0], strap_aneg_en};
      sd_sync_r <= {sd_sync_r[0], strap_full_duplex};
   end

   // effective speed or duplex; with no autoneg engine here
   // the outputs simply freeze while autoneg owns them
   function automatic logic eff_mode(input logic aneg, input logic held, input logic wr_bit);
      return aneg ? held : wr_bit;
   endfunction : eff_mode

   // register image; reserved and unimplemented bits read zero
   function automatic logic [15:0] bmc_image(input logic busy, input logic [4:0] mid,
      input logic dup);
      return {busy, mid, 1'b0, dup, 8'h00};
   endfunction : bmc_image

   // ahb address phase capture
   logic wr_pend_r;
   logic hit_r;
   wire addr_ok = hsel && hready && htrans[1];
   wire addr_hit = (haddr[11:0] == `PBMC_ADDR_BMC) && (haddr[31:12] == 20'h0_0000);
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_pend_r <= 1'b0;
         hit_r <= 1'b0;
      end else begin
         wr_pend_r <= addr_ok && hwrite;
         hit_r <= addr_hit;
      end
   end
   // unmapped addresses read zero and drop writes, still OKAY
   wire bmc_wr = wr_pend_r && hit_r;

   // register bits
   logic loop_r;
   logic speed_r;
   logic aneg_r;
   logic pdown_r;
   logic iso_r;
   logic duplex_r;
   pbmc_pkg::pbmc_state_t state_r;
   logic [15:0] cnt_r;
   wire in_srst = (state_r != pbmc_pkg::PBMC_RUN);
   // software writes are dropped during a soft reset; the restrap owns the bits
   wire sw_wr = bmc_wr && !in_srst;
   wire load_now = (state_r == pbmc_pkg::PBMC_LOAD);

   // soft reset sequencer: hold core reset, then restrap
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= pbmc_pkg::PBMC_LOAD;
         cnt_r <= 16'h0000;
      end else begin
         unique case (state_r)
            pbmc_pkg::PBMC_RUN: begin
               if (bmc_wr && hwdata[`PBMC_BIT_RESET]) begin
                  state_r <= pbmc_pkg::PBMC_SRST;
                  cnt_r <= RST_CYCLES;
               end
            end
            pbmc_pkg::PBMC_SRST: begin
               if (cnt_r <= 16'h0001) begin
                  state_r <= pbmc_pkg::PBMC_LOAD;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            pbmc_pkg::PBMC_LOAD: begin
               state_r <= pbmc_pkg::PBMC_RUN;
            end
         endcase
      end
   end

   // loopback bit; any reset or restrap leaves normal operation
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         loop_r <= 1'b0;
      end else if (load_now) begin
         loop_r <= 1'b0;
      end else if (sw_wr) begin
         loop_r <= hwdata[`PBMC_BIT_LOOP];
      end
   end

   // speed bit; strap at load, software afterwards
   // kept while autoneg runs so a later disable takes effect at once
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         speed_r <= 1'b0;
      end else if (load_now) begin
         speed_r <= ss_sync_r[1];
      end else if (sw_wr) begin
         speed_r <= hwdata[`PBMC_BIT_SPEED];
      end
   end

   // autoneg enable; strap at load, rewritable later
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         aneg_r <= 1'b0;
      end else if (load_now) begin
         aneg_r <= sa_sync_r[1];
      end else if (sw_wr) begin
         aneg_r <= hwdata[`PBMC_BIT_ANEG];
      end
   end

   // duplex bit; strap at load, software afterwards
   // kept while autoneg runs, like the speed bit
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         duplex_r <= 1'b0;
      end else if (load_now) begin
         duplex_r <= sd_sync_r[1];
      end else if (sw_wr) begin
         duplex_r <= hwdata[`PBMC_BIT_DUPLEX];
      end
   end

   // isolate bit; a restrap reconnects the port
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         iso_r <= 1'b0;
      end else if (load_now) begin
         iso_r <= 1'b0;
      end else if (sw_wr) begin
         iso_r <= hwdata[`PBMC_BIT_ISO];
      end
   end

   // power-down bit; pin assertion sets it and wins over a software clear
   // releasing the pin leaves the bit set until software clears it
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pdown_r <= 1'b0;
      end else if (load_now) begin
         pdown_r <= pin_pd;
      end else if (pin_pd) begin
         pdown_r <= 1'b1;
      end else if (sw_wr) begin
         pdown_r <= hwdata[`PBMC_BIT_PDOWN];
      end
   end

   // register image and read data for the next data phase
   wire [15:0] bmc_img = bmc_image(in_srst, {loop_r, speed_r, aneg_r, pdown_r, iso_r},
      duplex_r);
   wire [31:0] rd_nxt = (addr_ok && !hwrite && addr_hit) ? {16'h0000, bmc_img} : 32'h0000_0000;

   // derived controls
   wire pd_eff = pdown_r || pin_pd;
   wire spd_nxt = eff_mode(aneg_r, speed_100, speed_r);
   wire dup_nxt = eff_mode(aneg_r, full_duplex, duplex_r);
   // datapath gated off by power-down, isolate or soft reset; only registers survive
   wire path_on = !pd_eff && !iso_r && !in_srst;
   wire [3:0] rxd_nxt = loop_r ? mii_txd : line_rxd;
   wire rxdv_nxt = loop_r ? mii_tx_en : line_rx_dv;
   // loopback keeps transmit off the line
   wire tx_on = path_on && !loop_r;

   // bus answer: zero wait states, always okay
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hrdata <= rd_nxt;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // receive toward the mac; one cycle of latency in loopback
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mii_rxd <= 4'h0;
         mii_rx_dv <= 1'b0;
      end else begin
         mii_rxd <= path_on ? rxd_nxt : 4'h0;
         mii_rx_dv <= path_on && rxdv_nxt;
      end
   end

   // transmit toward the line
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         line_txd <= 4'h0;
         line_tx_en <= 1'b0;
      end else begin
         line_txd <= tx_on ? mii_txd : 4'h0;
         line_tx_en <= tx_on && mii_tx_en;
      end
   end

   // port enable and soft reset indication
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mii_out_en <= 1'b0;
         core_reset <= 1'b1;
      end else begin
         mii_out_en <= path_on;
         core_reset <= in_srst;
      end
   end

   // effective power and mode controls
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         power_down <= 1'b0;
         speed_100 <= 1'b0;
         full_duplex <= 1'b0;
         aneg_enable <= 1'b0;
      end else begin
         power_down <= pd_eff;
         speed_100 <= spd_nxt;
         full_duplex <= dup_nxt;
         aneg_enable <= aneg_r;
      end
   end

endmodule : pbmc_top

//--- shared/pbmc_cfg.svh
// constants for the basic mode control register block
`ifndef PBMC_CFG_SVH
`define PBMC_CFG_SVH
`define PBMC_ADDR_BMC 12'h000
`define PBMC_BIT_RESET 15
`define PBMC_BIT_LOOP 14
`define PBMC_BIT_SPEED 13
`define PBMC_BIT_ANEG 12
`define PBMC_BIT_PDOWN 11
`define PBMC_BIT_ISO 10
`define PBMC_BIT_DUPLEX 8
`define PBMC_RST_CYCLES 16'h0010
`endif

//--- shared/pbmc_pkg.sv
// types for the basic mode control register block
package pbmc_pkg;
   typedef enum logic [1:0] {
      PBMC_RUN,
      PBMC_SRST,
      PBMC_LOAD
   } pbmc_state_t;
endpackage : pbmc_pkg

//--- verif/pbmc_assertions.sv
// port checker for the mode control block
`timescale 1ns/1ps
module pbmc_chk (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic power_down_irq_pin_n,
   input wire logic power_down,
   input wire logic mii_out_en,
   input wire logic core_reset
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // bus stays alive in every mode; mii goes quiet while held down
   chk_ready_high: assert property (hreadyout) else $error("ready low");
   chk_resp_okay: assert property (!hresp) else $error("error resp");
   chk_upper_zero: assert property (hrdata[31:16] == 16'h0000) else $error("upper set");
   chk_gap_zero: assert property (!hrdata[9]) else $error("bit 9 set");
   chk_pin_pdown: assert property ($fell(power_down_irq_pin_n) |-> ##[1:4] power_down)
      else $error("pin ignored");
   chk_pin_level: assert property (!power_down_irq_pin_n [*4] |-> power_down)
      else $error("pin lost");
   chk_pdown_quiet: assert property (power_down && $past(power_down) |-> !mii_out_en)
      else $error("mii on in power down");
   chk_rst_quiet: assert property (core_reset && $past(core_reset) |-> !mii_out_en)
      else $error("mii on in reset");
endmodule : pbmc_chk
bind pbmc_top pbmc_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .power_down_irq_pin_n(power_down_irq_pin_n),
   .power_down(power_down), .mii_out_en(mii_out_en), .core_reset(core_reset));

//--- verif/pbmc_mac_model.sv
// mac side model driving transmit nibbles
`timescale 1ns/1ps
module pbmc_mac_model (
   input wire logic mclk,
   output logic [3:0] txd,
   output logic tx_en
);
   logic [4:0] cnt_r = 5'h00;
   // nibble moves every cycle so stale data never matches; no receive wait here
   always @(posedge mclk) cnt_r <= cnt_r + 5'h01;
   assign {tx_en, txd} = cnt_r;
endmodule : pbmc_mac_model

//--- verif/test_phy_basic_mode_control.sv
// bench for the mode control block
`timescale 1ns/1ps
module test_phy_basic_mode_control;
   logic mclk = 1'b0, sys_rst = 1'b1, hwrite = 1'b0, rd = 1'b0, pin_n = 1'b1, rdy;
   logic [1:0] htrans = 2'b00;
   logic [2:0] st = 3'b000;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
   logic [3:0] txd, rxd, t, ltx;
   logic tx_en, spd, dup, oen, crst, pdn, ane, te, dv;
   logic [15:0] q[$];
   int seed = 48, fails = 0, n_compared = 0;
   always #10 mclk = ~mclk;
   pbmc_mac_model i_mac (.mclk(mclk), .txd(txd), .tx_en(tx_en));
   pbmc_top #(.RST_CYCLES(16'h0004)) i_dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(), .strap_speed_100(st[2]),
      .strap_aneg_en(st[1]), .strap_full_duplex(st[0]), .power_down_irq_pin_n(pin_n),
      .mii_txd(txd), .mii_tx_en(tx_en), .line_rxd(4'h0), .line_rx_dv(1'b0), .mii_rxd(rxd),
      .mii_rx_dv(dv), .line_txd(ltx), .line_tx_en(), .mii_out_en(oen), .core_reset(crst),
      .power_down(pdn), .speed_100(spd), .full_duplex(dup), .aneg_enable(ane));
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x) fails++;
      if (s !== x) $display("ERROR at %0t seen %h expected %h", $time, s, x);
   endtask : chk
   task automatic end_of_test(input int extra);
      fails += extra;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   // bounded wait for hready; a hang ends the run as a failure
   task automatic wt;
      int k = 0;
      do @(posedge mclk); while (rdy !== 1'b1 && ++k < 50);
      if (k >= 50) end_of_test(1);
   endtask : wt
   // one single word transfer; a read leaves its expected value in the queue
   task automatic ahb(input logic w, input logic [15:0] d, input logic [31:0] a = 32'h0000_0000);
      if (!w) q.push_back(d);
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      wt;
      htrans <= 2'b00;
      hwdata <= {16'h0000, d};
      rd <= ~w;
      wt;
      rd <= 1'b0;
   endtask : ahb
   // the oldest expectation meets each read data phase
   always @(posedge mclk) begin
      if (rd && rdy === 1'b1) chk(hrdata, {16'h0000, q.pop_front()});
   end
   initial begin
      st <= 3'($random(seed));
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge mclk);
      // second reset once the straps have settled through the synchronisers
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge mclk);
      ahb(1'b0, 16'h0000, 32'h0000_0004);
      ahb(1'b0, {2'b00, st[2:1], 3'b000, st[0], 8'h00});
      chk({31'h0, ane}, {31'h0, st[1]});
      $display("test 1 done");
      ahb(1'b1, {2'b01, ~st[2], 4'h0, ~st[0], 8'h00});
      ahb(1'b0, {2'b01, ~st[2], 4'h0, ~st[0], 8'h00});
      #1 t = txd;
      te = tx_en;
      @(posedge mclk);
      #1 chk({28'h0, rxd}, {28'h0, t});
      chk({31'h0, dv}, {31'h0, te});
      chk({28'h0, ltx}, 32'h0000_0000);
      chk({31'h0, spd}, {31'h0, ~st[2]});
      chk({31'h0, dup}, {31'h0, ~st[0]});
      @(posedge mclk);
      $display("test 2 done");
      ahb(1'b1, {2'b00, st[2], 4'b1010, st[0], 8'h00});
      pin_n <= 1'b0;
      repeat (6) @(posedge mclk);
      chk({31'h0, spd}, {31'h0, ~st[2]});
      chk({31'h0, ane}, 32'h0000_0001);
      chk({31'h0, oen}, 32'h0000_0000);
      chk({31'h0, pdn}, 32'h0000_0001);
      pin_n <= 1'b1;
      ahb(1'b0, {2'b00, st[2], 4'b1110, st[0], 8'h00});
      $display("test 3 done");
      st <= ~st;
      ahb(1'b1, 16'h8000);
      repeat (3) @(posedge mclk);
      chk({31'h0, crst}, 32'h0000_0001);
      repeat (12) @(posedge mclk);
      ahb(1'b0, {2'b00, st[2:1], 3'b000, st[0], 8'h00});
      $display("test 4 done");
      end_of_test(0);
   end
endmodule : test_phy_basic_mode_control
